// >>> dbw_pkg.sv
// constants and types for the narrow-bus glue logic
package dbw_pkg;
  localparam int unsigned LANE_COUNT   = 4;
  localparam int unsigned LANE_BITS    = 8;
  localparam int unsigned DATA_WIDTH   = LANE_COUNT * LANE_BITS;
  localparam int unsigned WORD_ADDR_W  = 30;
  localparam int unsigned HALF_BITS    = 16;
  localparam logic [3:0]  LANES_NONE_N = 4'hf;

  typedef enum logic [1:0] {
    DBW_W32,
    DBW_W16,
    DBW_W8
  } dbw_width_t;

  typedef enum logic [1:0] {
    DBW_IDLE,
    DBW_ISSUE,
    DBW_WAIT,
    DBW_DONE
  } dbw_state_t;
endpackage

// >>> dbw_lane_decode.sv
// lane select to narrow-bus address and lane strobe decoder
`timescale 1ns/1ps
module dbw_lane_decode (
  input  wire logic [3:0] lane_select_n,
  output logic            halfword_address_bit,
  output logic            upper_lane_sel_n,
  output logic            lower_lane_sel_n
);
  logic [3:0] act;

  always_comb begin
    act = ~lane_select_n;
    // gapped or empty patterns are don't-care; the ~act[0] literal in the upper select changes the result only for gapped ones
    halfword_address_bit = ~(act[0] | act[1]);
    lower_lane_sel_n     = ~(act[0] | (act[2] & ~act[1]));
    upper_lane_sel_n     = ~(act[1] | (act[3] & ~act[0] & ~act[1]));
  end
endmodule // dbw_lane_decode

// >>> dbw_glue.sv
// address decode, bus sizing and byte swapping glue for narrow targets
`timescale 1ns/1ps
module dbw_glue #(
  parameter logic [29:0] HALF_BASE = 30'h0400_0000,
  parameter logic [29:0] HALF_MASK = 30'h3f00_0000,
  parameter logic [29:0] BYTE_BASE = 30'h0800_0000,
  parameter logic [29:0] BYTE_MASK = 30'h3f00_0000
) (
  input  wire logic                                core_clk,
  input  wire logic                                rst_n,
  input  wire logic                                cycle_start_strobe_n,
  input  wire logic [3:0]                          lane_select_n,
  input  wire logic [dbw_pkg::WORD_ADDR_W-1:0]     word_address,
  input  wire logic                                write_en,
  input  wire logic [dbw_pkg::DATA_WIDTH-1:0]      data_lanes_in,
  output logic      [dbw_pkg::DATA_WIDTH-1:0]      data_lanes_out,
  output logic                                     data_lanes_oe,
  output logic                                     ready_n,
  output logic                                     half_width_sel_n,
  output logic                                     byte_width_sel_n,
  output logic                                     tgt_req,
  output logic                                     tgt_we,
  output logic [1:0]                               tgt_width,
  output logic [dbw_pkg::WORD_ADDR_W-1:0]          tgt_word_address,
  output logic [3:0]                               tgt_lane_select_n,
  output logic                                     tgt_halfword_address_bit,
  output logic                                     tgt_byte_address_bit,
  output logic                                     tgt_upper_lane_sel_n,
  output logic                                     tgt_lower_lane_sel_n,
  output logic [dbw_pkg::DATA_WIDTH-1:0]           tgt_wdata,
  input  wire logic [dbw_pkg::DATA_WIDTH-1:0]      tgt_rdata,
  input  wire logic                                tgt_ack
);
  localparam int unsigned DW = dbw_pkg::DATA_WIDTH;

  logic                  rst_meta_reg;
  logic                  rst_sync_reg;

  dbw_pkg::dbw_state_t   state_reg;
  dbw_pkg::dbw_state_t   state_next;
  dbw_pkg::dbw_width_t   width_reg;
  dbw_pkg::dbw_width_t   width_next;
  logic [3:0]            lane_reg;
  logic [3:0]            lane_next;
  logic [29:0]           addr_reg;
  logic [29:0]           addr_next;
  logic                  we_reg;
  logic                  we_next;
  logic                  hbit_reg;
  logic                  hbit_next;
  logic                  upper_reg;
  logic                  upper_next;
  logic                  lower_reg;
  logic                  lower_next;
  logic [DW-1:0]         wdata_reg;
  logic [DW-1:0]         wdata_next;
  logic [DW-1:0]         rdata_reg;
  logic [DW-1:0]         rdata_next;
  logic                  ready_n_reg;
  logic                  ready_n_next;
  logic                  hsel_n_reg;
  logic                  hsel_n_next;
  logic                  bsel_n_reg;
  logic                  bsel_n_next;
  logic                  oe_reg;
  logic                  oe_next;
  logic                  req_reg;
  logic                  req_next;

  logic                  dec_hbit;
  logic                  dec_upper;
  logic                  dec_lower;
  dbw_pkg::dbw_width_t   region;
  logic [4:0]            shift_bits;

  // release of the async reset goes through two flops
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  dbw_lane_decode dbw_lane_decode_i (
    .lane_select_n        (lane_select_n),
    .halfword_address_bit (dec_hbit),
    .upper_lane_sel_n     (dec_upper),
    .lower_lane_sel_n     (dec_lower)
  );

  // width of the addressed target, fresh for every cycle
  always_comb begin
    if ((word_address & BYTE_MASK) == BYTE_BASE) begin
      region = dbw_pkg::DBW_W8;
    end else if ((word_address & HALF_MASK) == HALF_BASE) begin
      region = dbw_pkg::DBW_W16;
    end else begin
      region = dbw_pkg::DBW_W32;
    end
  end

  // bit offset of the addressed narrow unit within the 32-bit lanes
  always_comb begin
    unique case (width_reg)
      dbw_pkg::DBW_W16: shift_bits = {hbit_reg, 4'h0};
      dbw_pkg::DBW_W8:  shift_bits = {hbit_reg, lower_reg, 3'h0};
      default:          shift_bits = 5'h00;
    endcase
  end

  always_comb begin
    state_next   = state_reg;
    width_next   = width_reg;
    lane_next    = lane_reg;
    addr_next    = addr_reg;
    we_next      = we_reg;
    hbit_next    = hbit_reg;
    upper_next   = upper_reg;
    lower_next   = lower_reg;
    wdata_next   = wdata_reg;
    rdata_next   = rdata_reg;
    unique case (state_reg)
      dbw_pkg::DBW_IDLE: begin
        // every extra narrow cycle starts here anew with its own strobe
        if (!cycle_start_strobe_n) begin
          state_next = dbw_pkg::DBW_ISSUE;
          width_next = region;
          lane_next  = lane_select_n;
          addr_next  = word_address;
          we_next    = write_en;
          hbit_next  = dec_hbit;
          upper_next = dec_upper;
          lower_next = dec_lower;
        end
      end
      dbw_pkg::DBW_ISSUE: begin
        // bring the addressed bytes down to the target's low lanes
        wdata_next = data_lanes_in >> shift_bits;
        state_next = dbw_pkg::DBW_WAIT;
      end
      dbw_pkg::DBW_WAIT: begin
        if (tgt_ack) begin
          // narrow data goes back up onto the lanes of the addressed byte or halfword, with zeros on the others
          unique case (width_reg)
            dbw_pkg::DBW_W16: rdata_next = {16'h0000, tgt_rdata[15:0]} << shift_bits;
            dbw_pkg::DBW_W8:  rdata_next = {24'h00_0000, tgt_rdata[7:0]} << shift_bits;
            default:          rdata_next = tgt_rdata;
          endcase
          state_next = dbw_pkg::DBW_DONE;
        end
      end
      dbw_pkg::DBW_DONE: begin
        state_next = dbw_pkg::DBW_IDLE;
      end
    endcase
  end

  // pin outputs follow the next state so they change on the same edge
  always_comb begin
    ready_n_next = (state_next != dbw_pkg::DBW_DONE);
    oe_next      = (state_next == dbw_pkg::DBW_DONE) && !we_next;
    req_next     = (state_next == dbw_pkg::DBW_WAIT);
    // selects stand from the second clock through ready, sampled with it
    if (state_next == dbw_pkg::DBW_IDLE) begin
      hsel_n_next = 1'b1;
      bsel_n_next = 1'b1;
    end else begin
      hsel_n_next = (width_next != dbw_pkg::DBW_W16);
      bsel_n_next = (width_next != dbw_pkg::DBW_W8);
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      state_reg   <= dbw_pkg::DBW_IDLE;
      width_reg   <= dbw_pkg::DBW_W32;
      lane_reg    <= dbw_pkg::LANES_NONE_N;
      addr_reg    <= 30'h0000_0000;
      we_reg      <= 1'b0;
      hbit_reg    <= 1'b0;
      upper_reg   <= 1'b1;
      lower_reg   <= 1'b1;
      wdata_reg   <= 32'h0000_0000;
      rdata_reg   <= 32'h0000_0000;
      ready_n_reg <= 1'b1;
      hsel_n_reg  <= 1'b1;
      bsel_n_reg  <= 1'b1;
      oe_reg      <= 1'b0;
      req_reg     <= 1'b0;
    end else begin
      state_reg   <= state_next;
      width_reg   <= width_next;
      lane_reg    <= lane_next;
      addr_reg    <= addr_next;
      we_reg      <= we_next;
      hbit_reg    <= hbit_next;
      upper_reg   <= upper_next;
      lower_reg   <= lower_next;
      wdata_reg   <= wdata_next;
      rdata_reg   <= rdata_next;
      ready_n_reg <= ready_n_next;
      hsel_n_reg  <= hsel_n_next;
      bsel_n_reg  <= bsel_n_next;
      oe_reg      <= oe_next;
      req_reg     <= req_next;
    end
  end

  assign data_lanes_out           = rdata_reg;
  assign data_lanes_oe            = oe_reg;
  assign ready_n                  = ready_n_reg;
  assign half_width_sel_n         = hsel_n_reg;
  assign byte_width_sel_n         = bsel_n_reg;
  assign tgt_req                  = req_reg;
  assign tgt_we                   = we_reg;
  assign tgt_width                = width_reg;
  assign tgt_word_address         = addr_reg;
  assign tgt_lane_select_n        = lane_reg;
  assign tgt_halfword_address_bit = hbit_reg;
  assign tgt_byte_address_bit     = lower_reg;
  assign tgt_upper_lane_sel_n     = upper_reg;
  assign tgt_lower_lane_sel_n     = lower_reg;
  assign tgt_wdata                = wdata_reg;
endmodule // dbw_glue

// >>> dbw_glue_checker.sv
// port assertions for the narrow-bus glue
`timescale 1ns/1ps
module dbw_glue_checker (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic       cycle_start_strobe_n,
  input wire logic       ready_n,
  input wire logic       half_width_sel_n,
  input wire logic       byte_width_sel_n,
  input wire logic       data_lanes_oe,
  input wire logic       tgt_req,
  input wire logic       tgt_ack,
  input wire logic       tgt_we,
  input wire logic [1:0] tgt_width,
  input wire logic [3:0] tgt_lane_select_n,
  input wire logic       tgt_halfword_address_bit,
  input wire logic       tgt_byte_address_bit,
  input wire logic       tgt_upper_lane_sel_n,
  input wire logic       tgt_lower_lane_sel_n
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  a_ready_pulse: assert property (!ready_n |=> ready_n) else $error("long ready");
  a_ack_ready: assert property (tgt_req && tgt_ack |=> !ready_n && !tgt_req) else $error("no ready");
  a_strobe_req: assert property (!cycle_start_strobe_n |-> ##[2:3] tgt_req) else $error("no request");
  a_sel_idle: assert property (!ready_n |=> half_width_sel_n && byte_width_sel_n) else $error("sel left");
  a_sel_hold: assert property (tgt_req |=> $stable(half_width_sel_n) && $stable(byte_width_sel_n))
    else $error("sel moved");
  a_byte_width: assert property (!ready_n |-> byte_width_sel_n == (tgt_width != 2'h2)) else $error("byte sel");
  a_half_width: assert property (!ready_n && tgt_width != 2'h2 |-> half_width_sel_n == (tgt_width == 2'h0))
    else $error("half sel");
  a_read_drive: assert property (data_lanes_oe == (!ready_n && !tgt_we)) else $error("lane drive");
  a_hw_decode: assert property (tgt_req |-> tgt_halfword_address_bit == (&tgt_lane_select_n[1:0]))
    else $error("half bit");
  a_byte_bit: assert property (tgt_req |-> tgt_byte_address_bit ==
    !(!tgt_lane_select_n[0] || (!tgt_lane_select_n[2] && &tgt_lane_select_n[1:0]))) else $error("byte bit");
  a_upper_sel: assert property (tgt_req |-> tgt_upper_lane_sel_n ==
    !(!tgt_lane_select_n[1] || (!tgt_lane_select_n[3] && &tgt_lane_select_n[1:0]))) else $error("upper sel");
endmodule // dbw_glue_checker

// >>> dbw_cpu_model.sv
// processor model: runs bus cycles and splits them on width selects
`timescale 1ns/1ps
module dbw_cpu_model (
  input  wire logic        core_clk,
  input  wire logic        ready_n,
  input  wire logic        half_width_sel_n,
  input  wire logic        byte_width_sel_n,
  input  wire logic [31:0] data_lanes_out,
  output logic             cycle_start_strobe_n = 1'b1,
  output logic [3:0]       lane_select_n = 4'hf,
  output logic [29:0]      word_address = 30'h0,
  output logic             write_en = 1'b0,
  output logic [31:0]      data_lanes_in = 32'h0
);
  logic [31:0] rdata;
  int          cycles;
  task automatic xfer(input logic [3:0] ln, input logic [29:0] a, input logic w, input logic [31:0] d);
    logic [3:0] sm;
    cycles = 0;
    rdata = 32'hxxxx_xxxx;
    while (ln != 4'hf) begin
      @(posedge core_clk);
      #1 cycle_start_strobe_n = 1'b0;
      lane_select_n = ln;
      word_address = a;
      write_en = w;
      data_lanes_in = d ^ {{8{ln[3]}}, {8{ln[2]}}, {8{ln[1]}}, {8{ln[0]}}};
      @(posedge core_clk);
      #1 cycle_start_strobe_n = 1'b1;
      do @(posedge core_clk); while (ready_n !== 1'b0);
      // selects seen with ready pick the lanes taken and the next piece
      sm = ~ln & (!byte_width_sel_n ? ln + 4'h1 : !half_width_sel_n ? (&ln[1:0] ? 4'hc : 4'h3) : 4'hf);
      for (int i = 0; i < 4; i++)
        if (sm[i]) rdata[i*8+:8] = data_lanes_out[i*8+:8];
      ln = ln | sm;
      cycles++;
    end
    #1 data_lanes_in = ~data_lanes_in;
  endtask
endmodule // dbw_cpu_model

// >>> dbw_glue_tb.sv
// self-checking bench for the narrow-bus glue
`timescale 1ns/1ps
module dbw_glue_tb;
  logic        core_clk = 1'b0;
  logic        rst_n, cycle_start_strobe_n, write_en, data_lanes_oe, ready_n, tgt_req, tgt_we;
  logic        tgt_ack = 1'b0;
  logic        half_width_sel_n, byte_width_sel_n, tgt_halfword_address_bit, tgt_byte_address_bit;
  logic        tgt_upper_lane_sel_n, tgt_lower_lane_sel_n;
  logic [1:0]  tgt_width, ew;
  logic [3:0]  lane_select_n, tgt_lane_select_n, c;
  logic [29:0] word_address, tgt_word_address;
  logic [31:0] data_lanes_in, data_lanes_out, tgt_wdata, msk;
  logic [31:0] tgt_rdata = 32'h0;
  logic [15:0] rnd = 16'h1;
  logic [7:0]  base;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          sh;
  always #5 core_clk = ~core_clk;
  dbw_glue dbw_glue_i (.core_clk, .rst_n, .cycle_start_strobe_n, .lane_select_n, .word_address, .write_en,
    .data_lanes_in, .data_lanes_out, .data_lanes_oe, .ready_n, .half_width_sel_n, .byte_width_sel_n, .tgt_req,
    .tgt_we, .tgt_width, .tgt_word_address, .tgt_lane_select_n, .tgt_halfword_address_bit, .tgt_byte_address_bit,
    .tgt_upper_lane_sel_n, .tgt_lower_lane_sel_n, .tgt_wdata, .tgt_rdata, .tgt_ack);
  dbw_cpu_model dbw_cpu_model_i (.core_clk, .ready_n, .half_width_sel_n, .byte_width_sel_n, .data_lanes_out,
    .cycle_start_strobe_n, .lane_select_n, .word_address, .write_en, .data_lanes_in);
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [7:0] byte_of(input logic [7:0] a);
    return a ^ 8'ha5;
  endfunction
  function automatic logic [1:0] width_of(input logic [29:0] a);
    return (a[29:24] == 6'h08) ? 2'h2 : (a[29:24] == 6'h04) ? 2'h1 : 2'h0;
  endfunction
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    samples_checked++;
    if (got !== ex) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // narrow target: acks after a random wait, junk above its width
  always @(posedge core_clk) begin
    #1 rnd = lfsr(rnd);
    c = lane_select_n;
    ew = width_of(word_address);
    if (tgt_ack) tgt_ack = 1'b0;
    else if (tgt_req === 1'b1 && rnd[0]) begin
      base = {tgt_word_address[5:0], tgt_width != 2'h0 && tgt_halfword_address_bit,
              tgt_width == 2'h2 && tgt_byte_address_bit};
      tgt_rdata = tgt_width == 2'h0 ? {byte_of(base + 8'h3), byte_of(base + 8'h2), byte_of(base + 8'h1), byte_of(base)}
                : tgt_width == 2'h1 ? {rnd, byte_of(base + 8'h1), byte_of(base)} : {rnd, rnd[7:0], byte_of(base)};
      tgt_ack = 1'b1;
      sh = !c[0] ? 0 : !c[1] ? 1 : !c[2] ? 2 : 3;
      sh = ew == 2'h2 ? sh : ew == 2'h1 ? 2 * (&c[1:0]) : 0;
      msk = {{8{~c[3]}}, {8{~c[2]}}, {8{~c[1]}}, {8{~c[0]}}} >> (8 * sh);
      msk = msk & (ew == 2'h2 ? 32'h0000_00ff : ew == 2'h1 ? 32'h0000_ffff : 32'hffff_ffff);
      chk("width", ew, tgt_width);
      chk("half bit", &c[1:0], tgt_halfword_address_bit);
      chk("lower sel", !(!c[0] || (!c[2] && &c[1:0])), tgt_lower_lane_sel_n);
      chk("upper sel", !(!c[1] || (!c[3] && &c[1:0])), tgt_upper_lane_sel_n);
      chk("word", word_address, tgt_word_address);
      chk("we", write_en, tgt_we);
      if (write_en) chk("wdata", (data_lanes_in >> (8 * sh)) & msk, tgt_wdata & msk);
    end
  end
  initial begin
    logic [3:0] ln;
    logic [29:0] a;
    logic [15:0] s;
    int n;
    rst_n = 1'b0;
    s = 16'h1;
    repeat (16) @(posedge core_clk);
    #1 rst_n = 1'b1;
    chk("idle", 32'h1c, {ready_n, half_width_sel_n, byte_width_sel_n, data_lanes_oe, tgt_req});
    repeat (2) @(posedge core_clk);
    for (int r = 0; r < 3; r++) begin
      for (int i = 0; i < 20; i++) begin
        ln = 4'(40'hec80d91b37 >> (4 * (i % 10)));
        s = lfsr(s);
        a = {6'(4 * r), 18'h0, s[5:0]};
        dbw_cpu_model_i.xfer(ln, a, i >= 10, {s, ~s});
        n = width_of(a) == 2'h2 ? $countones(~ln) : (width_of(a) == 2'h1 && !(&ln[1:0]) && !(&ln[3:2])) ? 2 : 1;
        chk("cycles", n, dbw_cpu_model_i.cycles);
        for (int j = 0; j < 4; j++)
          if (i < 10 && !ln[j]) chk("rdata", byte_of({a[5:0], 2'(j)}), dbw_cpu_model_i.rdata[j*8+:8]);
      end
      $display("test %0d done", r);
    end
    // reset again in mid-run, then a line fill into the byte-wide region
    rst_n = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 rst_n = 1'b1;
    chk("idle again", 32'h1c, {ready_n, half_width_sel_n, byte_width_sel_n, data_lanes_oe, tgt_req});
    repeat (2) @(posedge core_clk);
    n = 0;
    for (int k = 0; k < 4; k++) begin
      a = {6'h08, 22'h0, 2'(k)};
      dbw_cpu_model_i.xfer(4'h0, a, 1'b0, {s, ~s});
      n += dbw_cpu_model_i.cycles;
      for (int j = 0; j < 4; j++)
        chk("fill data", byte_of({a[5:0], 2'(j)}), dbw_cpu_model_i.rdata[j*8+:8]);
    end
    chk("fill cycles", 16, n);
    $display("test fill done");
    stop_test;
  end
  initial begin
    #100000;
    error_cnt++;
    stop_test;
  end
endmodule // dbw_glue_tb
bind dbw_glue dbw_glue_checker dbw_glue_checker_i (.core_clk, .rst_n, .cycle_start_strobe_n, .ready_n,
  .half_width_sel_n, .byte_width_sel_n, .data_lanes_oe, .tgt_req, .tgt_ack, .tgt_we, .tgt_width,
  .tgt_lane_select_n, .tgt_halfword_address_bit, .tgt_byte_address_bit, .tgt_upper_lane_sel_n,
  .tgt_lower_lane_sel_n);
